//--- hdl/cpc_defs.vh
// Purpose: Register map, field positions and reset values of the core clock and power control block
// Assumes: 16-bit register words reached over a plain strobe port
// Notes:   Definitions only
`ifndef CPC_DEFS_VH
`define CPC_DEFS_VH

// ==================================================================
// Register offsets
`define CPC_ADDR_W          4
`define CPC_OFF_POWER_CTL   4'h0
`define CPC_OFF_SYNTH_CTL   4'h1
`define CPC_OFF_STATUS      4'h2

// ==================================================================
// Power control fields
`define CPC_PC_IRQ_A_WAKE   0
`define CPC_PC_IRQ_B_WAKE   1
`define CPC_PC_SERIAL_A     4
`define CPC_PC_SERIAL_B     5
`define CPC_PC_HOST_PORT    6
`define CPC_PC_TIMER        7
`define CPC_PC_SPARE        12
`define CPC_PC_HALT         13
`define CPC_PC_RING_SEL     14
`define CPC_PC_OSC_OFF      15
`define CPC_PC_MASK         16'hf0f3
`define CPC_PC_RESET        16'h0000

// ==================================================================
// Synthesizer control fields
`define CPC_SC_M_LSB        0
`define CPC_SC_M_MSB        4
`define CPC_SC_N_LSB        5
`define CPC_SC_N_MSB        7
`define CPC_SC_LF_LSB       8
`define CPC_SC_LF_MSB       11
`define CPC_SC_SELECT       14
`define CPC_SC_POWER_ON     15
`define CPC_SC_RESET        16'h0000
`define CPC_N_DIV1_CODE     3'h7
`define CPC_CODE_OFFSET     3'h2

// ==================================================================
// Status fields
`define CPC_ST_LOCK         0
`define CPC_ST_SYNTH_ACT    1
`define CPC_ST_RING_ACT     2
`define CPC_ST_CORE_RUN     3
`define CPC_ST_HALT         4

// ==================================================================
// Core clock source codes
`define CPC_SRC_REF         2'h0
`define CPC_SRC_SYNTH       2'h1
`define CPC_SRC_RING        2'h2

`endif

//--- hdl/cpc_switch_seq.v
// Purpose: Delayed, synchronous hand-over between reference and synthesizer clock
// Assumes: Wait counts are at least one cycle
// Notes:   A request withdrawn before the hand-over cancels it
`timescale 1ns/100ps

module cpc_switch_seq (
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // Request
  input  wire       target_synth,
  input  wire [5:0] wait_to_synth,
  input  wire [5:0] wait_to_ref,
  // Result
  output reg        synth_active_r
);

  reg  [5:0] count_r;
  reg        busy_r;

  // ==================================================================
  // Hand-over counter
  always @(posedge clk) begin
    if (!rstn) begin
      count_r        <= 6'h00;
      busy_r         <= 1'b0;
      synth_active_r <= 1'b0;
    end else if (target_synth == synth_active_r) begin
      busy_r  <= 1'b0;
      count_r <= 6'h00;
    end else if (!busy_r) begin
      busy_r  <= 1'b1;
      count_r <= target_synth ? wait_to_synth : wait_to_ref;
    end else if (count_r <= 6'h01) begin
      // Old clock keeps running until here, no partial pulse
      synth_active_r <= target_synth;
      busy_r         <= 1'b0;
      count_r        <= 6'h00;
    end else begin
      count_r <= count_r - 6'h01;
    end
  end

endmodule // cpc_switch_seq

//--- hdl/cpc_core_clock_power.v
// Purpose: Clock source selection, core clock halt and peripheral clock gating
// Assumes: Clock outputs are enables and selects for a glitch-free clock cell
// Notes:   Pins other than timer_ctl_disable pass two flip-flops before use
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "cpc_defs.vh"

// Notes on behaviour
// - Reset leaves synthesizer off and deselected
// - Synthesizer select switches clock after delay
// - To synthesizer within one to N+2
// - Back to reference within M/N+1 bounds
// - Oscillator off stops the core clock unless ring is the source
// - Ring select; ring powered while selected or still the active source
// - Halt bit stops core clock any source
// - Halt cleared by reset or wake pin
// - Synthesizer keeps running while halted
// - First wake pin clears halt, state kept
// - Second wake pin clears halt too
// - Serial port bits gate serial clocks
// - Host port bit gates host clock
// - Timer bit ORs with timer disable
// - Power register holds ten control bits
// - Synthesizer control write clears lock flag
// - Divider codes decode to M and N
// - Synthesizer output is half VCO rate
// - Clock-stop pin halts like halt bit
module cpc_core_clock_power (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rstn,
  // Register port
  input  wire [`CPC_ADDR_W-1:0] reg_addr,
  input  wire [15:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [15:0]            reg_rdata_r,
  // Pins
  input  wire                   ext_irq_a,
  input  wire                   ext_irq_b,
  input  wire                   clock_stop_n,
  input  wire                   synth_lock_in,
  input  wire                   timer_ctl_disable,
  // Synthesizer analog controls
  output reg                    synth_power_on,
  output reg  [4:0]             synth_m_value,
  output reg  [3:0]             synth_n_value,
  output reg  [3:0]             synth_loop_filter,
  // Clock source and power
  output reg  [1:0]             core_src_sel,
  output reg                    core_clock_run,
  output reg                    osc_power_off,
  output reg                    ring_osc_power_on,
  // Peripheral clock enables
  output reg                    serial_a_clk_en,
  output reg                    serial_b_clk_en,
  output reg                    host_port_clk_en,
  output reg                    timer_clk_en
);

  // ==================================================================
  // Registers and pin synchronisers
  reg  [15:0] power_ctl_reg_r;
  reg  [15:0] synth_ctl_reg_r;
  reg         lock_flag_r;
  reg  [3:0]  pin_meta_r;
  reg  [3:0]  pin_sync_r;
  reg         ring_active_r;
  reg         ring_pend_r;

  wire        wr_power = reg_wr && (reg_addr == `CPC_OFF_POWER_CTL);
  wire        wr_synth = reg_wr && (reg_addr == `CPC_OFF_SYNTH_CTL);
  wire        irq_a_s  = pin_sync_r[0];
  wire        irq_b_s  = pin_sync_r[1];
  wire        stop_n_s = pin_sync_r[2];
  wire        lock_s   = pin_sync_r[3];
  wire        synth_active;

  always @(posedge clk) begin
    if (!rstn) begin
      pin_meta_r <= 4'h4;
      pin_sync_r <= 4'h4;
    end else begin
      pin_meta_r <= {synth_lock_in, clock_stop_n, ext_irq_b, ext_irq_a};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==================================================================
  // Divider decode
  reg  [4:0] m_dec;
  reg  [3:0] n_dec;
  reg  [5:0] wait_up;
  reg  [5:0] wait_down;
  reg  [4:0] m_over_n;

  always @* begin
    m_dec = synth_ctl_reg_r[`CPC_SC_M_MSB:`CPC_SC_M_LSB] + {2'h0, `CPC_CODE_OFFSET};
    if (synth_ctl_reg_r[`CPC_SC_N_MSB:`CPC_SC_N_LSB] == `CPC_N_DIV1_CODE) begin
      n_dec = 4'h1;
    end else begin
      n_dec = {1'b0, synth_ctl_reg_r[`CPC_SC_N_MSB:`CPC_SC_N_LSB]} + {1'b0, `CPC_CODE_OFFSET};
    end
    m_over_n  = m_dec / {1'b0, n_dec};
    wait_up   = {2'h0, n_dec} + 6'h02;
    wait_down = {1'b0, m_over_n} + 6'h01;
  end

  // ==================================================================
  // Power control register
  always @(posedge clk) begin
    if (!rstn) begin
      power_ctl_reg_r <= `CPC_PC_RESET;
    end else if (wr_power) begin
      // Only the ten defined bits are kept
      power_ctl_reg_r <= reg_wdata & `CPC_PC_MASK;
    end else if ((irq_a_s && power_ctl_reg_r[`CPC_PC_IRQ_A_WAKE]) ||
                 (irq_b_s && power_ctl_reg_r[`CPC_PC_IRQ_B_WAKE])) begin
      // Only the halt bit drops, other state stays intact
      power_ctl_reg_r[`CPC_PC_HALT] <= 1'b0;
    end
  end

  // ==================================================================
  // Synthesizer control and lock flag
  always @(posedge clk) begin
    if (!rstn) begin
      synth_ctl_reg_r <= `CPC_SC_RESET;
      lock_flag_r     <= 1'b0;
    end else if (wr_synth) begin
      synth_ctl_reg_r <= reg_wdata;
      lock_flag_r     <= 1'b0;
    end else if (lock_s && synth_ctl_reg_r[`CPC_SC_POWER_ON]) begin
      lock_flag_r     <= 1'b1;
    end else if (!synth_ctl_reg_r[`CPC_SC_POWER_ON]) begin
      lock_flag_r     <= 1'b0;
    end
  end

  // ==================================================================
  // Source hand-over
  cpc_switch_seq u_switch (
    .clk            (clk),
    .rstn           (rstn),
    .target_synth   (synth_ctl_reg_r[`CPC_SC_SELECT]),
    .wait_to_synth  (wait_up),
    .wait_to_ref    (wait_down),
    .synth_active_r (synth_active)
  );

  // Ring change lands two cycles on, giving old clock time to finish
  always @(posedge clk) begin
    if (!rstn) begin
      ring_pend_r   <= 1'b0;
      ring_active_r <= 1'b0;
    end else begin
      ring_pend_r   <= power_ctl_reg_r[`CPC_PC_RING_SEL];
      ring_active_r <= ring_pend_r;
    end
  end

  // ==================================================================
  // Clock and power outputs
  reg         halt_now;
  reg  [1:0]  src_nxt;

  always @* begin
    // Pin stop behaves as the halt bit
    halt_now = power_ctl_reg_r[`CPC_PC_HALT] || !stop_n_s;
    if (ring_active_r) begin
      src_nxt = `CPC_SRC_RING;
    end else if (synth_active) begin
      src_nxt = `CPC_SRC_SYNTH;
    end else begin
      src_nxt = `CPC_SRC_REF;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      core_src_sel      <= `CPC_SRC_REF;
      core_clock_run    <= 1'b0;
      osc_power_off     <= 1'b0;
      ring_osc_power_on <= 1'b0;
      synth_power_on    <= 1'b0;
      synth_m_value     <= 5'h00;
      synth_n_value     <= 4'h0;
      synth_loop_filter <= 4'h0;
      serial_a_clk_en   <= 1'b0;
      serial_b_clk_en   <= 1'b0;
      host_port_clk_en  <= 1'b0;
      timer_clk_en      <= 1'b0;
    end else begin
      core_src_sel      <= src_nxt;
      // Oscillator off starves a clock taken from it
      core_clock_run    <= !halt_now && !(power_ctl_reg_r[`CPC_PC_OSC_OFF] &&
                           (src_nxt != `CPC_SRC_RING));
      osc_power_off     <= power_ctl_reg_r[`CPC_PC_OSC_OFF];
      // Ring stays powered until the core source has left the ring
      ring_osc_power_on <= power_ctl_reg_r[`CPC_PC_RING_SEL] || ring_active_r;
      // Halt does not touch the synthesizer
      synth_power_on    <= synth_ctl_reg_r[`CPC_SC_POWER_ON];
      synth_m_value     <= m_dec;
      synth_n_value     <= n_dec;
      synth_loop_filter <= synth_ctl_reg_r[`CPC_SC_LF_MSB:`CPC_SC_LF_LSB];
      serial_a_clk_en   <= !power_ctl_reg_r[`CPC_PC_SERIAL_A];
      serial_b_clk_en   <= !power_ctl_reg_r[`CPC_PC_SERIAL_B];
      host_port_clk_en  <= !power_ctl_reg_r[`CPC_PC_HOST_PORT];
      timer_clk_en      <= !(power_ctl_reg_r[`CPC_PC_TIMER] || timer_ctl_disable);
    end
  end

  // ==================================================================
  // Read port, data one cycle after the strobe
  reg  [15:0] rd_mux;

  always @* begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `CPC_OFF_POWER_CTL: rd_mux = power_ctl_reg_r;
      `CPC_OFF_SYNTH_CTL: rd_mux = synth_ctl_reg_r;
      `CPC_OFF_STATUS: begin
        rd_mux[`CPC_ST_LOCK]      = lock_flag_r;
        rd_mux[`CPC_ST_SYNTH_ACT] = synth_active;
        rd_mux[`CPC_ST_RING_ACT]  = ring_active_r;
        rd_mux[`CPC_ST_CORE_RUN]  = core_clock_run;
        rd_mux[`CPC_ST_HALT]      = power_ctl_reg_r[`CPC_PC_HALT];
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux;
    end else begin
      reg_rdata_r <= 16'h0000;
    end
  end

endmodule // cpc_core_clock_power

//--- test/cpc_assertions.sv
// Purpose: Port assertions for cpc_core_clock_power
// Assumes: One clock, sync reset, divide two and multiply twenty
// Notes:   Bounds allow for pin sync stages
`timescale 1ns/100ps
`include "cpc_defs.vh"
module cpc_chk (
  // Clock and register port
  input wire        clk,
  input wire        rstn,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  // Pins and outputs
  input wire        clock_stop_n,
  input wire        synth_power_on,
  input wire [1:0]  core_src_sel,
  input wire        core_clock_run,
  input wire        osc_power_off,
  input wire        ring_osc_power_on,
  input wire        serial_a_clk_en,
  input wire        host_port_clk_en
);
  // ==========================================
  // Sequences
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence pc_wr;
    reg_wr && reg_addr == `CPC_OFF_POWER_CTL;
  endsequence
  sequence sc_wr;
    reg_wr && reg_addr == `CPC_OFF_SYNTH_CTL;
  endsequence
  // ==========================================
  // Checks
  reset_idle_a: assert property ($rose(rstn) |-> !synth_power_on && core_src_sel == `CPC_SRC_REF)
    else $error("synth not idle after reset");
  to_synth_a: assert property (sc_wr and (reg_wdata[14] && core_src_sel == `CPC_SRC_REF && !ring_osc_power_on)
    |=> core_src_sel == `CPC_SRC_REF ##[1:8] core_src_sel == `CPC_SRC_SYNTH) else $error("late synth switch");
  to_ref_a: assert property (sc_wr and (!reg_wdata[14] && core_src_sel == `CPC_SRC_SYNTH)
    |=> (core_src_sel == `CPC_SRC_SYNTH) [*8] ##[1:30] core_src_sel == `CPC_SRC_REF) else $error("bad ref switch");
  halt_write_a: assert property (pc_wr and reg_wdata[13] |-> ##[1:2] !core_clock_run)
    else $error("halt did not stop clock");
  ring_power_a: assert property (core_src_sel == `CPC_SRC_RING |-> ring_osc_power_on)
    else $error("ring source unpowered");
  ring_sel_a: assert property (pc_wr and reg_wdata[14] && !reg_wdata[13] |-> ##[1:5] core_src_sel == `CPC_SRC_RING)
    else $error("ring not selected");
  stop_pin_a: assert property ((!clock_stop_n) [*3] |-> ##[0:1] !core_clock_run)
    else $error("stop pin ignored");
  gate_write_a: assert property (pc_wr ##1 (!reg_wr) [*2] |-> serial_a_clk_en == !$past(reg_wdata[4], 2)
    && host_port_clk_en == !$past(reg_wdata[6], 2) && osc_power_off == $past(reg_wdata[15], 2))
    else $error("gate bits not applied");
  synth_keep_a: assert property (!core_clock_run && synth_power_on && !reg_wr |=> synth_power_on)
    else $error("synth dropped while halted");
endmodule // cpc_chk

bind cpc_core_clock_power cpc_chk chk_u (.*);

//--- test/cpc_loop_model.sv
// Purpose: Analog loop stand-in giving the lock indication
// Assumes: Lock needs a settling time after power on
// Notes:   Never reports lock at once, so polling is exercised
`timescale 1ns/100ps
module cpc_loop_model #(
  parameter LOCK_CYCLES = 12
) (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Loop
  input  wire power_on,
  output reg  lock
);
  reg [7:0] cnt_r;
  // ==========================================
  // Settling, restarts when powered down
  always @(posedge clk) begin
    if (!rstn || !power_on) begin
      cnt_r <= 8'h00;
      lock  <= 1'b0;
    end else if (cnt_r == LOCK_CYCLES) begin
      lock  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // cpc_loop_model

//--- test/test_core_clock_power_control.sv
// Purpose: Self-checking bench for cpc_core_clock_power
// Assumes: Loop model on the far side of the lock input
// Notes:   Checks at an edge see values from before it
`timescale 1ns/100ps
`include "cpc_defs.vh"
module test_core_clock_power_control;
  reg         clk;
  reg         rstn;
  reg  [3:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg  [1:0]  irq_v;
  reg         clock_stop_n;
  reg         timer_dis;
  reg  [15:0] rd_data;
  integer     bad_count;
  integer     tests_run;
  integer     i;
  wire [15:0] rdata;
  wire        lock;
  wire        s_pwr;
  wire [4:0]  m_val;
  wire [3:0]  lf_val;
  wire [3:0]  n_val;
  wire [1:0]  src;
  wire        run;
  wire        ring_on;
  wire [3:0]  gates;
  // ==========================================
  // Design and far side
  cpc_core_clock_power dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata), .ext_irq_a(irq_v[0]), .ext_irq_b(irq_v[1]),
    .clock_stop_n(clock_stop_n), .synth_lock_in(lock), .timer_ctl_disable(timer_dis),
    .synth_power_on(s_pwr), .synth_m_value(m_val), .synth_n_value(n_val), .synth_loop_filter(lf_val),
    .core_src_sel(src), .core_clock_run(run), .osc_power_off(), .ring_osc_power_on(ring_on),
    .serial_a_clk_en(gates[3]), .serial_b_clk_en(gates[2]), .host_port_clk_en(gates[1]),
    .timer_clk_en(gates[0]));
  cpc_loop_model #(.LOCK_CYCLES(12)) loop_u (.clk(clk), .rstn(rstn), .power_on(s_pwr), .lock(lock));
  // ==========================================
  // Bus and check tasks
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task idle(input integer n);
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk);
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      reg_addr  <= a;
      reg_wdata <= d;
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b1;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a);
    begin
      reg_addr <= a;
      reg_wr   <= 1'b0;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      rd_data = rdata;
    end
  endtask
  task test_done;
    begin
      if (bad_count == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    begin
      chk(s_pwr, 1'b0);
      rd(`CPC_OFF_SYNTH_CTL);
      chk(rd_data, `CPC_SC_RESET);
      rd(`CPC_OFF_POWER_CTL);
      chk(rd_data, `CPC_PC_RESET);
      rd(4'h9);
      chk(rd_data, 16'h0000);
    end
  endtask
  task t_synth;
    begin
      wr(`CPC_OFF_SYNTH_CTL, 16'h2912);
      // Decoded values reach the outputs one edge after the register
      idle(2);
      chk({lf_val, n_val, m_val}, {4'h9, 4'h2, 5'h14});
      wr(`CPC_OFF_SYNTH_CTL, 16'ha912);
      rd_data = 16'h0000;
      for (i = 0; i < 20 && !rd_data[0]; i = i + 1)
        rd(`CPC_OFF_STATUS);
      chk(rd_data[0], 1'b1);
      wr(`CPC_OFF_SYNTH_CTL, 16'he912);
      rd(`CPC_OFF_STATUS);
      chk(rd_data[0], 1'b0);
      idle(8);
      chk(src, `CPC_SRC_SYNTH);
      rd(`CPC_OFF_STATUS);
      chk(rd_data, 16'h000b);
      wr(`CPC_OFF_SYNTH_CTL, 16'ha912);
      idle(10);
      chk(src, `CPC_SRC_SYNTH);
      idle(10);
      chk(src, `CPC_SRC_REF);
    end
  endtask
  task t_halt;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        wr(`CPC_OFF_POWER_CTL, 16'h2000 | (16'h0001 << i));
        idle(4);
        chk({s_pwr, run}, 2'b10);
        irq_v <= 2'b10 >> i;
        idle(3);
        irq_v <= 2'b00;
        idle(6);
        chk(run, 1'b0);
        irq_v <= 2'b01 << i;
        idle(3);
        irq_v <= 2'b00;
        idle(6);
        chk(run, 1'b1);
        rd(`CPC_OFF_POWER_CTL);
        chk(rd_data, 16'h0001 << i);
      end
    end
  endtask
  task t_gates;
    begin
      wr(`CPC_OFF_POWER_CTL, 16'h00f0);
      idle(3);
      chk(gates, 4'h0);
      wr(`CPC_OFF_POWER_CTL, 16'h5fff);
      idle(5);
      rd(`CPC_OFF_POWER_CTL);
      chk(rd_data, 16'h50f3);
      chk({ring_on, src}, {1'b1, `CPC_SRC_RING});
      wr(`CPC_OFF_POWER_CTL, 16'hc000);
      idle(5);
      chk({run, gates}, 5'h1f);
      wr(`CPC_OFF_POWER_CTL, 16'h8000);
      idle(6);
      chk({ring_on, run}, 2'b00);
      timer_dis <= 1'b1;
      wr(`CPC_OFF_POWER_CTL, 16'h0000);
      idle(5);
      chk({run, gates}, 5'h1e);
      timer_dis <= 1'b0;
      idle(2);
      chk(gates, 4'hf);
      clock_stop_n <= 1'b0;
      idle(5);
      chk(run, 1'b0);
      clock_stop_n <= 1'b1;
      idle(5);
      chk(run, 1'b1);
    end
  endtask
  // ==========================================
  // Clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count = bad_count + 1;
    test_done;
  end
  initial begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    irq_v = 2'b00;
    clock_stop_n = 1'b1;
    timer_dis = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    idle(3);
    t_reset;
    t_synth;
    t_halt;
    t_gates;
    test_done;
  end
endmodule // test_core_clock_power_control
